// >>> hdl/omdec_top.v
// Memory map decoder routing host byte accesses to channel, shared and expansion targets
//
// Notes on behaviour
// - Channel n's 16-byte register block sits at n*0x400, its low eight bytes a standard UART set.
// - Offsets 0x80..0x9A of every window all reach the one shared configuration register set.
// - A read at window offset 0x100..0x1FF pops the next byte of that channel's receive FIFO.
// - A write at window offset 0x100..0x1FF pushes the byte into that channel's transmit FIFO.
// - Window offsets 0x200..0x3FF read receive data with its line status, and writes do nothing.
// - Host addresses 0x2000..0x3FFF are forwarded to the expansion port for channels 8 to 15.
// - Writes to shared bytes 0x88..0x8B through a window change only that window's channel bit.
// - The decoder claims 8K of eight contiguous 1024-byte channel windows from the base.
`timescale 1ns/1ps
`include "omdec_defs.vh"

module omdec_top (
    input wire CLK_I,
    input wire ARST_N_I,
    // Host request and answer
    input wire REQ_VALID_I,
    input wire REQ_WRITE_I,
    input wire [`OMD_ADDR_W-1:0] REQ_ADDR_I,
    input wire [7:0] REQ_WDATA_I,
    output wire REQ_READY_O,
    output wire RSP_VALID_O,
    output wire [7:0] RSP_RDATA_O,
    // Common target address and data
    output wire [2:0] TGT_CH_O,
    output wire [9:0] TGT_OFS_O,
    output wire TGT_WE_O,
    output wire [7:0] TGT_WDATA_O,
    // Channel register blocks
    output wire UREG_STB_O,
    input wire [7:0] UREG_RDATA_I,
    // Shared configuration registers
    output wire CFG_STB_O,
    output wire [7:0] CFG_WMASK_O,
    input wire [7:0] CFG_RDATA_I,
    // Receive and transmit FIFOs
    output wire RXF_POP_O,
    input wire [7:0] RXF_DATA_I,
    input wire [7:0] RXF_LINE_STATUS_BYTE_I,
    output wire TXF_PUSH_O,
    // Expansion port
    output wire EXP_STB_O,
    output wire [`OMD_EXP_ADDR_HI:0] EXP_ADDR_O,
    input wire [7:0] EXP_RDATA_I,
    input wire EXP_ACK_I
);

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_ISSUE = 2'b01;
    localparam ST_RESP = 2'b10;

    reg [1:0] state_r;
    reg [1:0] state_nxt;

    // Latched request
    reg [2:0] region_r;
    reg [2:0] ch_r;
    reg [9:0] ofs_r;
    reg we_r;
    reg [7:0] wdata_r;
    reg [7:0] mask_r;
    reg [`OMD_EXP_ADDR_HI:0] exp_addr_r;

    // Answer and the data byte held back from a paired status read
    reg [7:0] rdata_r;
    reg [7:0] rdata_nxt;
    reg [7:0] hold_r;

    wire [2:0] dec_region;
    wire [2:0] dec_ch;
    wire [9:0] dec_ofs;
    wire [7:0] dec_mask;
    wire accept;
    wire issue;
    wire done;
    wire rx_pair_low;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Eight 1024-byte windows plus the expansion half
    omdec_region_decode u_dec (
        .addr_i(REQ_ADDR_I),
        .region_o(dec_region),
        .chan_o(dec_ch),
        .ofs_o(dec_ofs),
        .lane_mask_o(dec_mask)
    );

    // ------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------
    // One access in flight; the host sees back-pressure until answered
    assign REQ_READY_O = (state_r == ST_IDLE);
    assign accept = REQ_VALID_I && REQ_READY_O;
    assign issue = (state_r == ST_ISSUE);
    // Local targets answer at once, the expansion side when it acks
    assign done = issue && ((region_r != `OMD_RG_EXP) || EXP_ACK_I);
    assign RSP_VALID_O = (state_r == ST_RESP);
    assign RSP_RDATA_O = rdata_r;

    // Even byte of a status pair pops; the odd one replays the data
    assign rx_pair_low = !ofs_r[0];

    // ------------------------------------------------------------
    // Target strobes
    // ------------------------------------------------------------
    // Local target strobes are one-cycle pulses in the issue cycle
    assign UREG_STB_O = issue && (region_r == `OMD_RG_UREG);
    assign CFG_STB_O = issue && (region_r == `OMD_RG_CFG);
    assign TXF_PUSH_O = issue && (region_r == `OMD_RG_FIFO) && we_r;
    assign RXF_POP_O = issue && !we_r && ((region_r == `OMD_RG_FIFO)
        || ((region_r == `OMD_RG_RXERR) && rx_pair_low));
    // Held until the expansion side acknowledges
    assign EXP_STB_O = issue && (region_r == `OMD_RG_EXP);

    assign TGT_CH_O = ch_r;
    assign TGT_OFS_O = ofs_r;
    assign TGT_WE_O = we_r;
    assign TGT_WDATA_O = wdata_r;
    assign CFG_WMASK_O = mask_r;
    assign EXP_ADDR_O = exp_addr_r;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Next state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    state_nxt = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                if (done) begin
                    state_nxt = ST_RESP;
                end
            end
            ST_RESP: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Read data selection; writes and reserved gaps answer zero
    always @* begin
        rdata_nxt = `OMD_BYTE_ZERO;
        if (!we_r) begin
            case (region_r)
                `OMD_RG_UREG: begin
                    rdata_nxt = UREG_RDATA_I;
                end
                `OMD_RG_CFG: begin
                    rdata_nxt = CFG_RDATA_I;
                end
                `OMD_RG_FIFO: begin
                    rdata_nxt = RXF_DATA_I;
                end
                `OMD_RG_RXERR: begin
                    if (rx_pair_low) begin
                        rdata_nxt = RXF_LINE_STATUS_BYTE_I;
                    end else begin
                        rdata_nxt = hold_r;
                    end
                end
                `OMD_RG_EXP: begin
                    rdata_nxt = EXP_RDATA_I;
                end
                default: begin
                    rdata_nxt = `OMD_BYTE_ZERO;
                end
            endcase
        end
    end

    // State register
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Request latch; fields stay stable through issue and answer
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            region_r <= `OMD_RG_RSVD;
            ch_r <= `OMD_CH_ZERO;
            ofs_r <= `OMD_OFS_ZERO;
            we_r <= 1'b0;
            wdata_r <= `OMD_BYTE_ZERO;
            mask_r <= `OMD_MASK_ALL;
            exp_addr_r <= `OMD_EXP_ZERO;
        end else if (accept) begin
            region_r <= dec_region;
            ch_r <= dec_ch;
            ofs_r <= dec_ofs;
            we_r <= REQ_WRITE_I;
            wdata_r <= REQ_WDATA_I;
            mask_r <= dec_mask;
            exp_addr_r <= REQ_ADDR_I[`OMD_EXP_ADDR_HI:0];
        end
    end

    // Answer byte, captured when the target completes
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_r <= `OMD_BYTE_ZERO;
        end else if (done) begin
            rdata_r <= rdata_nxt;
        end
    end

    // Data byte popped with its status, kept for the odd half of the pair.
    // Only one holding byte exists, so pairs must not be interleaved.
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            hold_r <= `OMD_BYTE_ZERO;
        end else if (issue && !we_r && (region_r == `OMD_RG_RXERR) && rx_pair_low) begin
            hold_r <= RXF_DATA_I;
        end
    end

endmodule

// >>> common/omdec_defs.vh
// Address map constants of the octal channel memory map decoder
`ifndef OMDEC_DEFS_VH
`define OMDEC_DEFS_VH

// ----------------------------------------------------------------
// Host address layout
// ----------------------------------------------------------------
`define OMD_ADDR_W 14
`define OMD_EXP_BIT 13
`define OMD_CH_HI 12
`define OMD_CH_LO 10
`define OMD_OFS_HI 9
`define OMD_EXP_ADDR_HI 12

// ----------------------------------------------------------------
// Offsets inside one 1024-byte channel window
// ----------------------------------------------------------------
`define OMD_UREG_FIRST 10'h000
`define OMD_UREG_LAST 10'h00F
`define OMD_CFG_FIRST 10'h080
`define OMD_CFG_LAST 10'h09A
`define OMD_LANE_FIRST 10'h088
`define OMD_LANE_LAST 10'h08B
`define OMD_FIFO_FIRST 10'h100
`define OMD_FIFO_LAST 10'h1FF
`define OMD_RXERR_FIRST 10'h200
`define OMD_RXERR_LAST 10'h3FF

// ----------------------------------------------------------------
// Region codes
// ----------------------------------------------------------------
`define OMD_RG_RSVD 3'h0
`define OMD_RG_UREG 3'h1
`define OMD_RG_CFG 3'h2
`define OMD_RG_FIFO 3'h3
`define OMD_RG_RXERR 3'h4
`define OMD_RG_EXP 3'h5

// ----------------------------------------------------------------
// Reset and fill values
// ----------------------------------------------------------------
`define OMD_BYTE_ZERO 8'h00
`define OMD_CH_ZERO 3'h0
`define OMD_OFS_ZERO 10'h000
`define OMD_EXP_ZERO 13'h0000
`define OMD_MASK_ALL 8'hFF
`define OMD_MASK_ONE 8'h01

`endif

// >>> hdl/omdec_region_decode.v
// Combinational decode of a host address into region, channel and lane mask
`timescale 1ns/1ps
`include "omdec_defs.vh"

module omdec_region_decode (
    input wire [`OMD_ADDR_W-1:0] addr_i,
    output reg [2:0] region_o,
    output wire [2:0] chan_o,
    output wire [9:0] ofs_o,
    output reg [7:0] lane_mask_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Inclusive offset range test, used for every window region
    function in_range;
        input [9:0] ofs;
        input [9:0] lo;
        input [9:0] hi;
        begin
            in_range = (ofs >= lo) && (ofs <= hi);
        end
    endfunction

    assign chan_o = addr_i[`OMD_CH_HI:`OMD_CH_LO];
    assign ofs_o = addr_i[`OMD_OFS_HI:0];

    // Region select, upper half goes out to the expansion port
    always @* begin
        region_o = `OMD_RG_RSVD;
        if (addr_i[`OMD_EXP_BIT]) begin
            region_o = `OMD_RG_EXP;
        end else if (in_range(ofs_o, `OMD_RXERR_FIRST, `OMD_RXERR_LAST)) begin
            region_o = `OMD_RG_RXERR;
        end else if (in_range(ofs_o, `OMD_FIFO_FIRST, `OMD_FIFO_LAST)) begin
            region_o = `OMD_RG_FIFO;
        end else if (in_range(ofs_o, `OMD_UREG_FIRST, `OMD_UREG_LAST)) begin
            region_o = `OMD_RG_UREG;
        end else if (in_range(ofs_o, `OMD_CFG_FIRST, `OMD_CFG_LAST)) begin
            region_o = `OMD_RG_CFG;
        end
    end

    // Shared per-channel bytes only take the caller's own bit
    always @* begin
        lane_mask_o = `OMD_MASK_ALL;
        if (in_range(ofs_o, `OMD_LANE_FIRST, `OMD_LANE_LAST)) begin
            lane_mask_o = `OMD_MASK_ONE << chan_o;
        end
    end

endmodule

// >>> test/omdec_top_asserts.sv
// Concurrent checks on the decoder's host and target ports
`timescale 1ns/1ps
`include "omdec_defs.vh"
module omdec_top_asserts (
    input wire CLK_I, ARST_N_I, REQ_VALID_I, REQ_WRITE_I, REQ_READY_O, RSP_VALID_O,
    input wire UREG_STB_O, CFG_STB_O, RXF_POP_O, TXF_PUSH_O, EXP_STB_O, TGT_WE_O,
    input wire [`OMD_ADDR_W-1:0] REQ_ADDR_I,
    input wire [7:0] REQ_WDATA_I, RSP_RDATA_O, TGT_WDATA_O, CFG_WMASK_O,
    input wire [2:0] TGT_CH_O,
    input wire [9:0] TGT_OFS_O,
    input wire [`OMD_EXP_ADDR_HI:0] EXP_ADDR_O
);
    // --------
    // Decode of the request taken at this edge
    // --------
    wire tk = REQ_VALID_I && REQ_READY_O;
    wire loc = tk && !REQ_ADDR_I[13];
    wire [9:0] ofs = REQ_ADDR_I[9:0];
    wire [2:0] chn = REQ_ADDR_I[12:10];
    wire gap = (ofs >= 10'h010 && ofs < 10'h080) || (ofs > 10'h09A && ofs < 10'h100);
    wire fifo = ofs[9:8] == 2'b01;
    // A refused access must leave every target untouched
    wire none = !(UREG_STB_O | CFG_STB_O | RXF_POP_O | TXF_PUSH_O | EXP_STB_O);
    default clocking dcb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    AST_UREG_BLOCK: assert property (loc && ofs < 10'h010 |=>
        UREG_STB_O && TGT_CH_O == $past(chn)) else $error("register block not reached");
    AST_CFG_SHARED: assert property (loc && ofs >= 10'h080 && ofs <= 10'h09A |=>
        CFG_STB_O && TGT_OFS_O == $past(ofs)) else $error("shared registers not reached");
    AST_LANE_MASK: assert property (loc && REQ_WRITE_I && ofs >= 10'h088 && ofs <= 10'h08B |=>
        CFG_WMASK_O == (8'h01 << $past(chn))) else $error("lane mask wrong");
    AST_RX_POP: assert property (loc && !REQ_WRITE_I && fifo |=>
        RXF_POP_O && !TXF_PUSH_O) else $error("receive pop missing");
    AST_TX_PUSH: assert property (loc && REQ_WRITE_I && fifo |=>
        TXF_PUSH_O && TGT_WDATA_O == $past(REQ_WDATA_I)) else $error("transmit push wrong");
    AST_RXERR_RO: assert property (loc && REQ_WRITE_I && ofs[9] |=>
        none ##1 RSP_VALID_O && RSP_RDATA_O == 8'h00) else $error("status area write acted");
    AST_GAP_ZERO: assert property (loc && gap |=>
        none ##1 RSP_VALID_O && RSP_RDATA_O == 8'h00) else $error("reserved gap acted");
    AST_EXP_FWD: assert property (tk && REQ_ADDR_I[13] |=>
        EXP_STB_O && EXP_ADDR_O == $past(REQ_ADDR_I[12:0])) else $error("expansion not used");
    AST_LOCAL_ANSWER: assert property (loc |=>
        !REQ_READY_O ##1 RSP_VALID_O) else $error("local answer late");
    AST_DIR_KEPT: assert property (tk |=>
        TGT_WE_O == $past(REQ_WRITE_I)) else $error("direction not kept");
endmodule
bind omdec_top omdec_top_asserts chk_u (.*);

// >>> test/omdec_far_model.sv
// Target-side model: register blocks, shared registers, receive FIFO, expansion slave
`timescale 1ns/1ps
module omdec_far_model (
    input wire CLK_I, ARST_N_I, RXF_POP_O, EXP_STB_O,
    input wire [2:0] TGT_CH_O,
    input wire [9:0] TGT_OFS_O,
    input wire [12:0] EXP_ADDR_O,
    input wire [3:0] EXP_WAIT,
    output wire [7:0] UREG_RDATA_I, CFG_RDATA_I, RXF_DATA_I, RXF_LINE_STATUS_BYTE_I, EXP_RDATA_I,
    output wire EXP_ACK_I
);
    reg [7:0] cnt_r;
    reg [3:0] wcnt_r;
    // Data tied to the address so a misrouted access shows up
    assign UREG_RDATA_I = {1'b0, TGT_CH_O, TGT_OFS_O[3:0]};
    assign CFG_RDATA_I = TGT_OFS_O[7:0];
    assign RXF_DATA_I = cnt_r ^ {TGT_CH_O, 5'h00};
    assign RXF_LINE_STATUS_BYTE_I = ~RXF_DATA_I;
    assign EXP_ACK_I = EXP_STB_O && (wcnt_r == EXP_WAIT);
    // Inverse outside the ack cycle, so early sampling cannot pass
    assign EXP_RDATA_I = (EXP_ADDR_O[7:0] ^ 8'h5A) ^ {8{!EXP_ACK_I}};
    // Head advances per pop; wait count runs while the strobe stands
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cnt_r <= 8'h00;
            wcnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + {7'h00, RXF_POP_O};
            wcnt_r <= (EXP_STB_O && !EXP_ACK_I) ? wcnt_r + 4'h1 : 4'h0;
        end
    end
endmodule

// >>> test/omdec_tb_top.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch at %0t: got %0h want %0h", $time, a, b); end end
module omdec_tb_top;
    logic CLK_I = 0, ARST_N_I = 0, REQ_VALID_I = 0, REQ_WRITE_I = 0;
    logic [13:0] REQ_ADDR_I = 0;
    logic [7:0] REQ_WDATA_I = 0, RSP_RDATA_O, TGT_WDATA_O, CFG_WMASK_O, UREG_RDATA_I;
    logic [7:0] CFG_RDATA_I, RXF_DATA_I, RXF_LINE_STATUS_BYTE_I, EXP_RDATA_I, got, pops, held;
    logic REQ_READY_O, RSP_VALID_O, TGT_WE_O, UREG_STB_O, CFG_STB_O, RXF_POP_O, TXF_PUSH_O;
    logic EXP_STB_O, EXP_ACK_I;
    logic [2:0] TGT_CH_O;
    logic [9:0] TGT_OFS_O;
    logic [12:0] EXP_ADDR_O;
    logic [3:0] EXP_WAIT = 0;
    logic [4:0] st;
    logic [7:0] mask_w;
    int miscompares = 0, compares = 0, lat;
    // Row: write, address, write byte, strobes {ureg, cfg, pop, push, exp}
    logic [27:0] rows [15] = '{{1'b0, 14'h1C0F, 8'h00, 5'h10}, {1'b1, 14'h1C03, 8'h33, 5'h10},
        {1'b0, 14'h0480, 8'h00, 5'h08}, {1'b1, 14'h1C8B, 8'h0F, 5'h08},
        {1'b0, 14'h0100, 8'h00, 5'h04}, {1'b0, 14'h05FF, 8'h00, 5'h04},
        {1'b1, 14'h0D80, 8'hA5, 5'h02}, {1'b0, 14'h0202, 8'h00, 5'h04},
        {1'b0, 14'h0203, 8'h00, 5'h00}, {1'b1, 14'h03FF, 8'h77, 5'h00},
        {1'b0, 14'h0010, 8'h00, 5'h00}, {1'b0, 14'h1C9B, 8'h00, 5'h00},
        {1'b1, 14'h00FF, 8'h11, 5'h00}, {1'b0, 14'h2345, 8'h00, 5'h01},
        {1'b1, 14'h3FFF, 8'h22, 5'h01}};
    omdec_top dut_u (.*);
    omdec_far_model far_u (.*);
    always #12.5 CLK_I = ~CLK_I;
    // Expected read byte; tracks the FIFO head the way the targets do
    function automatic logic [7:0] expect_rd(input logic w, input logic [13:0] a);
        logic [9:0] o = a[9:0];
        logic [7:0] v = pops ^ {a[12:10], 5'h00};
        if (w) return 8'h00;
        if (a[13]) return a[7:0] ^ 8'h5A;
        if (o < 10'h010) return {1'b0, a[12:10], o[3:0]};
        if (o >= 10'h080 && o <= 10'h09A) return o[7:0];
        if (o[9:8] == 2'b01 || (o[9] && !o[0])) pops++;
        if (o[9] && !o[0]) held = v;
        if (o[9:8] == 2'b01) return v;
        if (o[9]) return o[0] ? held : ~v;
        return 8'h00;
    endfunction
    // One host transfer; strobes are gathered until the answer
    task automatic xfer(input logic w, input logic [13:0] a, input logic [7:0] d);
        logic [7:0] want;
        st = 5'h00;
        lat = 0;
        REQ_VALID_I = 1;
        REQ_WRITE_I = w;
        REQ_ADDR_I = a;
        REQ_WDATA_I = d;
        @(negedge CLK_I);
        REQ_VALID_I = 0;
        while (RSP_VALID_O !== 1'b1 && lat < 40) begin
            st = st | {UREG_STB_O, CFG_STB_O, RXF_POP_O, TXF_PUSH_O, EXP_STB_O};
            @(negedge CLK_I);
            lat++;
        end
        got = RSP_RDATA_O;
        // Evaluated once: the expectation advances the FIFO head model
        want = expect_rd(w, a);
        `CHK(got, want)
        @(negedge CLK_I);
    endtask
    task automatic wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence: table rows, slow slave, reset mid-transfer
    initial begin
        pops = 8'h00;
        held = 8'h00;
        repeat (3) @(negedge CLK_I);
        ARST_N_I = 1;
        @(negedge CLK_I);
        for (int i = 0; i < 15; i++) begin
            xfer(rows[i][27], rows[i][26:13], rows[i][12:5]);
            `CHK(st, rows[i][4:0])
            `CHK(lat, 1)
            // Latched target fields still stand after the answer
            mask_w = 8'hFF;
            if (rows[i][22:13] >= 10'h088 && rows[i][22:13] <= 10'h08B)
                mask_w = 8'h01 << rows[i][25:23];
            `CHK({TGT_WE_O, TGT_CH_O, TGT_OFS_O}, {rows[i][27], rows[i][25:13]})
            `CHK(TGT_WDATA_O, rows[i][12:5])
            `CHK(CFG_WMASK_O, mask_w)
            `CHK(EXP_ADDR_O, rows[i][25:13])
        end
        EXP_WAIT = 4'h5;
        xfer(1'b0, 14'h3C07, 8'h00);
        `CHK(lat, 6)
        REQ_VALID_I = 1;
        REQ_WRITE_I = 0;
        REQ_ADDR_I = 14'h0602;
        @(negedge CLK_I);
        REQ_VALID_I = 0;
        ARST_N_I = 0;
        @(negedge CLK_I);
        `CHK({REQ_READY_O, RXF_POP_O, RSP_RDATA_O}, 10'h200)
        ARST_N_I = 1;
        pops = 8'h00;
        held = 8'h00;
        @(negedge CLK_I);
        xfer(1'b0, 14'h0603, 8'h00);
        wrap_up;
    end
    // Far beyond the fewer than a hundred cycles the sequence needs
    initial begin
        #100000;
        miscompares++;
        wrap_up;
    end
endmodule
